// [dv/nfc_flash_model.sv]
`timescale 1ns/10ps
// Behavioural flash; samples on the falling clock after a strobe rise to avoid races
module nfc_flash_model (
    input wire logic mclk,
    input wire logic [7:0] busy_cyc,
    input wire logic cs_n,
    input wire logic cle,
    input wire logic ale,
    input wire logic we_n,
    input wire logic [15:0] io,
    output logic ready_busy_n,
    output logic cap_valid,
    output logic [1:0] cap_kind,
    output logic [15:0] cap_word,
    output logic viol
);
    logic we_q = 1'b1;
    logic [7:0] busy_ff = 8'h00;
    logic [7:0] cmd_ff = 8'h00;
    logic [2:0] naddr_ff = 3'h0;
    logic [39:0] addr_ff = 40'h0;
    logic die_ff = 1'b0;
    logic [2:0] need;
    initial begin
        cap_valid = 1'b0;
        cap_kind = 2'h0;
        cap_word = 16'h0000;
        viol = 1'b0;
    end
    assign ready_busy_n = (busy_ff == 8'h00);
    assign need = (cmd_ff == 8'h60) ? 3'h3 : ((cmd_ff == 8'h05) ? 3'h2 : 3'h5);
    always @(negedge mclk) begin
        we_q <= we_n;
        cap_valid <= 1'b0;
        if (busy_ff != 8'h00) begin
            busy_ff <= busy_ff - 8'h01;
        end
        if ((!we_n && cs_n) || (cle && ale && !cs_n)) begin
            viol <= 1'b1;
        end
        if (we_n && !we_q && !cs_n) begin
            cap_valid <= 1'b1;
            cap_kind <= cle ? 2'h1 : (ale ? 2'h2 : 2'h0);
            cap_word <= io;
            if ((cle || ale) && io[15:8] != 8'h00) begin
                viol <= 1'b1;
            end
            if (cle) begin
                cmd_ff <= io[7:0];
                naddr_ff <= 3'h0;
                if (busy_ff != 8'h00 && !(io[7:0] inside {8'hff, 8'h70})) begin
                    viol <= 1'b1;
                end
                if (!(io[7:0] inside {8'h00, 8'h30, 8'h35, 8'h90, 8'hff, 8'h80, 8'h10,
                        8'h85, 8'h60, 8'hd0, 8'h05, 8'he0, 8'h70})) begin
                    viol <= 1'b1;
                end
                if (io[7:0] inside {8'h30, 8'h35, 8'h10, 8'hd0, 8'hff}) begin
                    busy_ff <= busy_cyc;
                end
            end
            if (ale && naddr_ff < need) begin
                addr_ff[{naddr_ff, 3'b000} +: 8] <= io[7:0];
                naddr_ff <= naddr_ff + 3'h1;
                if (naddr_ff == 3'h4) begin
                    die_ff <= io[1];
                end
            end
        end
    end
endmodule // nfc_flash_model

// [dv/nfc_host_assertions.sv]
`timescale 1ns/10ps
module nfc_host_checker (
    input wire logic MCLK,
    input wire logic RSTN,
    input wire logic DEV_READY,
    input wire logic CHIP_SELECT_N,
    input wire logic COMMAND_LATCH_ENABLE,
    input wire logic ADDRESS_LATCH_ENABLE,
    input wire logic WRITE_STROBE_N,
    input wire logic [15:0] IO_OUT,
    input wire logic IO_OE
);
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RSTN);

    property p_strobe_sel;
        !WRITE_STROBE_N |-> !CHIP_SELECT_N && IO_OE;
    endproperty
    a_strobe_sel: assert property (p_strobe_sel)
        else $error("write strobe low without select or drive");
    property p_pulse;
        $fell(WRITE_STROBE_N) |-> !WRITE_STROBE_N [*3];
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("write strobe pulse too short");
    property p_low_stable;
        !WRITE_STROBE_N && $past(!WRITE_STROBE_N) |-> $stable(IO_OUT);
    endproperty
    a_low_stable: assert property (p_low_stable)
        else $error("bus value moved while strobe low");
    // Device latches on the rising edge, so nothing may move in that cycle
    property p_edge_hold;
        $rose(WRITE_STROBE_N) |-> $stable(IO_OUT) && $stable(COMMAND_LATCH_ENABLE)
            && $stable(ADDRESS_LATCH_ENABLE) && !CHIP_SELECT_N;
    endproperty
    a_edge_hold: assert property (p_edge_hold)
        else $error("bus qualifiers moved at strobe rise");
    property p_one_type;
        !(COMMAND_LATCH_ENABLE && ADDRESS_LATCH_ENABLE);
    endproperty
    a_one_type: assert property (p_one_type)
        else $error("command and address latch both high");
    property p_upper;
        (COMMAND_LATCH_ENABLE || ADDRESS_LATCH_ENABLE) && !WRITE_STROBE_N |->
            IO_OUT[15:8] == 8'h00;
    endproperty
    a_upper: assert property (p_upper)
        else $error("upper lines not low in command or address cycle");
    property p_legal;
        COMMAND_LATCH_ENABLE && !WRITE_STROBE_N |-> IO_OUT[7:0] inside {8'h00, 8'h30,
            8'h35, 8'h90, 8'hff, 8'h80, 8'h10, 8'h85, 8'h60, 8'hd0, 8'h05, 8'he0, 8'h70};
    endproperty
    a_legal: assert property (p_legal)
        else $error("undefined command code issued");
    property p_busy;
        COMMAND_LATCH_ENABLE && $fell(WRITE_STROBE_N) && !DEV_READY |->
            IO_OUT[7:0] inside {8'hff, 8'h70};
    endproperty
    a_busy: assert property (p_busy)
        else $error("command other than reset or status while busy");
endmodule // nfc_host_checker

// [dv/test_nfc_host.sv]
`timescale 1ns/10ps
module test_nfc_host;
    typedef logic [17:0] nfc_cyc_t;
    typedef struct packed {
        logic [2:0] op; logic [11:0] col; logic [17:0] row;
        logic single; logic [3:0] n; logic [7:0] last;
    } nfc_row_s;
    logic MCLK, RSTN, REQ_VALID, SINGLE_DIE, RND_VALID, RND_OUT, DIN_VALID;
    logic [2:0] REQ_OP;
    logic [11:0] REQ_COL;
    logic [17:0] REQ_ROW;
    logic [15:0] DIN_DATA;
    logic [7:0] busy_cyc;
    wire logic REQ_READY, DIN_READY, OP_DONE, DEV_READY, CHIP_SELECT_N, IO_OE, OUTPUT_STROBE_N;
    wire logic COMMAND_LATCH_ENABLE, ADDRESS_LATCH_ENABLE, WRITE_STROBE_N, READY_BUSY_N;
    wire logic cap_valid, viol;
    wire logic [1:0] cap_kind;
    wire logic [15:0] IO_OUT, cap_word;
    int error_cnt = 0;
    int n_checks = 0;
    nfc_cyc_t exp_q[$];
    nfc_cyc_t cap_q[$];
    logic [15:0] din_q[$];
    nfc_row_s r;
    nfc_row_s rows[8] = '{
        '{nfc_pkg::OP_READ, 12'hfff, 18'h3ffff, 1'b0, 4'h7, 8'h30},
        '{nfc_pkg::OP_READ_ID, 12'h000, 18'h00000, 1'b0, 4'h1, 8'h90},
        '{nfc_pkg::OP_CPB_READ, 12'h000, 18'h20001, 1'b1, 4'h7, 8'h35},
        '{nfc_pkg::OP_RESET, 12'h000, 18'h00000, 1'b0, 4'h1, 8'hff},
        '{nfc_pkg::OP_PROG, 12'h123, 18'h1a5c3, 1'b0, 4'h7, 8'h10},
        '{nfc_pkg::OP_CPB_PROG, 12'h801, 18'h2c00f, 1'b0, 4'h7, 8'h10},
        '{nfc_pkg::OP_ERASE, 12'hfff, 18'h2aaaa, 1'b0, 4'h5, 8'hd0},
        '{nfc_pkg::OP_STATUS, 12'h000, 18'h00000, 1'b0, 4'h1, 8'h70}};

    nfc_host i_nfc_host (.MCLK(MCLK), .RSTN(RSTN), .REQ_VALID(REQ_VALID), .REQ_OP(REQ_OP),
        .REQ_COL(REQ_COL), .REQ_ROW(REQ_ROW), .SINGLE_DIE(SINGLE_DIE), .RND_VALID(RND_VALID),
        .RND_OUT(RND_OUT), .DIN_VALID(DIN_VALID), .DIN_DATA(DIN_DATA),
        .READY_BUSY_N(READY_BUSY_N), .REQ_READY(REQ_READY), .DIN_READY(DIN_READY),
        .OP_DONE(OP_DONE), .DEV_READY(DEV_READY), .CHIP_SELECT_N(CHIP_SELECT_N),
        .COMMAND_LATCH_ENABLE(COMMAND_LATCH_ENABLE), .ADDRESS_LATCH_ENABLE(ADDRESS_LATCH_ENABLE),
        .WRITE_STROBE_N(WRITE_STROBE_N), .OUTPUT_STROBE_N(OUTPUT_STROBE_N), .IO_OUT(IO_OUT),
        .IO_OE(IO_OE));
    nfc_flash_model i_nfc_flash_model (.mclk(MCLK), .busy_cyc(busy_cyc), .cs_n(CHIP_SELECT_N),
        .cle(COMMAND_LATCH_ENABLE), .ale(ADDRESS_LATCH_ENABLE), .we_n(WRITE_STROBE_N),
        .io(IO_OUT), .ready_busy_n(READY_BUSY_N), .cap_valid(cap_valid), .cap_kind(cap_kind),
        .cap_word(cap_word), .viol(viol));

    always #5 MCLK = ~MCLK;

    always @(posedge MCLK) begin
        if (cap_valid === 1'b1) begin
            cap_q.push_back({cap_kind, cap_word});
        end
        if (DIN_READY === 1'b1 && DIN_VALID) begin
            void'(din_q.pop_front());
            if (din_q.size() == 0) DIN_VALID <= 1'b0;
            else DIN_DATA <= din_q[0];
        end
    end

    task automatic summarize();
        $display("Checks made %0d, mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string nm, input nfc_cyc_t e, input nfc_cyc_t g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    function automatic void add_addr(input nfc_row_s a, input bit with_col);
        if (with_col) exp_q.push_back({10'h200, a.col[7:0]});
        if (with_col) exp_q.push_back({10'h200, 4'h0, a.col[11:8]});
        exp_q.push_back({10'h200, a.row[7:0]});
        exp_q.push_back({10'h200, a.row[15:8]});
        exp_q.push_back({10'h200, 6'h00, a.row[17] & ~a.single, a.row[16]});
    endfunction

    function automatic void build(input nfc_row_s a);
        exp_q.delete();
        case (a.op)
            nfc_pkg::OP_READ, nfc_pkg::OP_CPB_READ, nfc_pkg::OP_PROG, nfc_pkg::OP_CPB_PROG: begin
                exp_q.push_back({10'h100, a.op == nfc_pkg::OP_PROG ? 8'h80 :
                    (a.op == nfc_pkg::OP_CPB_PROG ? 8'h85 : 8'h00)});
                add_addr(a, 1'b1);
            end
            nfc_pkg::OP_ERASE: begin
                exp_q.push_back({10'h100, 8'h60});
                add_addr(a, 1'b0);
            end
            default: ;
        endcase
        exp_q.push_back({10'h100, a.last});
    endfunction

    task automatic cmp_seq();
        chk("bus cycle count", 18'(exp_q.size()), 18'(cap_q.size()));
        foreach (exp_q[i]) chk("bus cycle", exp_q[i], cap_q.size() > i ? cap_q[i] : 18'hx);
    endtask

    task automatic settle();
        int k;
        k = 0;
        while (!(DEV_READY === 1'b1 && REQ_READY === 1'b1) && k < 3000) begin
            @(posedge MCLK);
            k++;
        end
    endtask

    // Holds the request until the edge that takes it; stop cuts the wait for completion
    task automatic run(input nfc_row_s a, input logic rnd, input logic rnd_out, input int stop);
        int k;
        cap_q.delete();
        @(posedge MCLK);
        REQ_VALID <= ~rnd;
        RND_VALID <= rnd;
        RND_OUT <= rnd_out;
        REQ_OP <= a.op;
        REQ_COL <= a.col;
        REQ_ROW <= a.row;
        SINGLE_DIE <= a.single;
        k = 0;
        do begin
            @(posedge MCLK);
            k++;
        // A reposition has no ready; it is taken once the pins go active
        end while ((rnd ? CHIP_SELECT_N !== 1'b0 : REQ_READY !== 1'b1) && k < 3000);
        REQ_VALID <= 1'b0;
        RND_VALID <= 1'b0;
        if (stop > 0) begin
            repeat (stop) @(posedge MCLK);
            return;
        end
        k = 0;
        while (OP_DONE !== 1'b1 && k < 3000) begin
            @(posedge MCLK);
            k++;
        end
        chk("operation done", 18'h1, {17'h0, OP_DONE});
        repeat (6) @(posedge MCLK);
    endtask

    task automatic chk_idle();
        chk("pins in reset", 18'h001c0, {9'h0, OUTPUT_STROBE_N, CHIP_SELECT_N, WRITE_STROBE_N,
            COMMAND_LATCH_ENABLE, ADDRESS_LATCH_ENABLE, IO_OE, REQ_READY, OP_DONE, DIN_READY});
    endtask

    initial begin
        MCLK = 1'b0;
        RSTN = 1'b0;
        {REQ_VALID, SINGLE_DIE, RND_VALID, RND_OUT, DIN_VALID} = 5'h00;
        REQ_OP = 3'h0;
        REQ_COL = 12'h000;
        REQ_ROW = 18'h00000;
        DIN_DATA = 16'h0000;
        busy_cyc = 8'h28;
        repeat (12) @(posedge MCLK);
        chk_idle();
        RSTN <= 1'b1;
        foreach (rows[i]) begin
            settle();
            build(rows[i]);
            run(rows[i], 1'b0, 1'b0, 0);
            chk("cycle count", 18'(rows[i].n), 18'(cap_q.size()));
            chk("last code", {10'h100, rows[i].last}, cap_q[$]);
            cmp_seq();
        end
        busy_cyc = 8'h02;
        r = rows[0];
        r.col = 12'h5a7;
        exp_q = '{{10'h100, 8'h05}, {10'h200, 8'ha7}, {10'h200, 8'h05}, {10'h100, 8'he0}};
        settle();
        run(r, 1'b1, 1'b1, 0);
        cmp_seq();
        exp_q = '{{10'h100, 8'h85}, {10'h200, 8'ha7}, {10'h200, 8'h05}};
        settle();
        run(r, 1'b1, 1'b0, 0);
        cmp_seq();
        settle();
        build(rows[4]);
        exp_q.insert(6, {2'h0, 16'h1234});
        exp_q.insert(6, {2'h0, 16'habcd});
        din_q = '{16'habcd, 16'h1234};
        DIN_DATA <= 16'habcd;
        DIN_VALID <= 1'b1;
        run(rows[4], 1'b0, 1'b0, 0);
        cmp_seq();
        busy_cyc = 8'hc8;
        settle();
        run(rows[6], 1'b0, 1'b0, 0);
        run(rows[7], 1'b0, 1'b0, 0);
        chk("status code", {10'h100, 8'h70}, cap_q[0]);
        run(rows[4], 1'b0, 1'b0, 0);
        chk("program after busy", {10'h100, 8'h80}, cap_q[0]);
        settle();
        run(rows[0], 1'b0, 1'b0, 20);
        RSTN <= 1'b0;
        repeat (3) @(posedge MCLK);
        chk_idle();
        RSTN <= 1'b1;
        settle();
        build(rows[7]);
        run(rows[7], 1'b0, 1'b0, 0);
        cmp_seq();
        chk("flash protocol faults", 18'h0, {17'h0, viol});
        summarize();
    end

    initial begin
        repeat (40000) @(posedge MCLK);
        error_cnt++;
        $display("MISMATCH watchdog expected finish seen hang");
        summarize();
    end
endmodule // test_nfc_host

bind nfc_host nfc_host_checker i_nfc_host_checker (.MCLK(MCLK), .RSTN(RSTN),
    .DEV_READY(DEV_READY), .CHIP_SELECT_N(CHIP_SELECT_N),
    .COMMAND_LATCH_ENABLE(COMMAND_LATCH_ENABLE), .ADDRESS_LATCH_ENABLE(ADDRESS_LATCH_ENABLE),
    .WRITE_STROBE_N(WRITE_STROBE_N), .IO_OUT(IO_OUT), .IO_OE(IO_OE));

// [logic/nfc_host.sv]
`timescale 1ns/10ps
module nfc_host (
    input wire logic MCLK,
    input wire logic RSTN,
    input wire logic REQ_VALID,
    input wire logic [2:0] REQ_OP,
    input wire logic [11:0] REQ_COL,
    input wire logic [17:0] REQ_ROW,
    input wire logic SINGLE_DIE,
    input wire logic RND_VALID,
    input wire logic RND_OUT,
    input wire logic DIN_VALID,
    input wire logic [15:0] DIN_DATA,
    input wire logic READY_BUSY_N,
    output logic REQ_READY,
    output logic DIN_READY,
    output logic OP_DONE,
    output logic DEV_READY,
    output logic CHIP_SELECT_N,
    output logic COMMAND_LATCH_ENABLE,
    output logic ADDRESS_LATCH_ENABLE,
    output logic WRITE_STROBE_N,
    output logic OUTPUT_STROBE_N,
    output logic [15:0] IO_OUT,
    output logic IO_OE
);
    typedef enum logic [2:0] {IDLE, LOOK, SETUP, LOW, HIGH, DATA, RNDLOOK} nfc_st_e;
    typedef struct packed {
        nfc_st_e st;
        logic [2:0] op;
        logic [2:0] step;
        logic [3:0] cnt;
        logic [11:0] col;
        logic [17:0] row;
        logic single;
        logic rnd;
        logic rnd_out;
        logic [1:0] kind;
        logic [2:0] aidx;
        logic data_ph;
        logic rb_m;
        logic rb_s;
        logic req_ready;
        logic din_ready;
        logic done;
        logic cs_n;
        logic cle;
        logic ale;
        logic we_n;
        logic [15:0] io;
        logic oe;
    } nfc_state_s;

    nfc_state_s cur_ff, nxt_ff;
    logic [1:0] rom_kind;
    logic [7:0] rom_code;
    logic rom_last;
    logic [2:0] rom_op;
    logic [2:0] rom_step;

    // Address byte n of the column/row layout, die bit forced low for one-die parts
    function automatic logic [7:0] addr_byte(input logic [2:0] idx, input logic [11:0] col,
                                            input logic [17:0] row, input logic single);
        logic [7:0] b;
        b = 8'h00;
        case (idx)
            3'h0: b = col[7:0];
            3'h1: b = {4'h0, col[11:8]};
            3'h2: b = row[7:0];
            3'h3: b = row[15:8];
            3'h4: b = {6'h00, row[17] & ~single, row[16]};
            default: b = 8'h00;
        endcase
        return b;
    endfunction

    // Random-data sequences are short and built here rather than in the table
    assign rom_op = cur_ff.op;
    assign rom_step = cur_ff.step;

    nfc_seq_rom u_rom (
        .MCLK(MCLK),
        .op(rom_op),
        .step(rom_step),
        .kind(rom_kind),
        .code(rom_code),
        .last(rom_last)
    );

    always_comb begin
        nxt_ff = cur_ff;
        nxt_ff.rb_m = READY_BUSY_N;
        nxt_ff.rb_s = cur_ff.rb_m;
        nxt_ff.done = 1'b0;
        nxt_ff.din_ready = 1'b0;
        nxt_ff.req_ready = 1'b0;
        case (cur_ff.st)
            IDLE: begin
                nxt_ff.cs_n = 1'b1;
                nxt_ff.cle = 1'b0;
                nxt_ff.ale = 1'b0;
                nxt_ff.we_n = 1'b1;
                nxt_ff.oe = 1'b0;
                // Random repositioning only while the page is ready
                if (RND_VALID && cur_ff.rb_s && !cur_ff.req_ready) begin
                    nxt_ff.rnd = 1'b1;
                    nxt_ff.rnd_out = RND_OUT;
                    nxt_ff.col = REQ_COL;
                    nxt_ff.step = 3'h0;
                    nxt_ff.st = RNDLOOK;
                end else if (REQ_VALID && cur_ff.req_ready) begin
                    nxt_ff.op = REQ_OP;
                    nxt_ff.col = REQ_COL;
                    nxt_ff.row = REQ_ROW;
                    nxt_ff.single = SINGLE_DIE;
                    nxt_ff.rnd = 1'b0;
                    nxt_ff.step = 3'h0;
                    nxt_ff.aidx = 3'h0;
                    nxt_ff.st = LOOK;
                end else begin
                    // Busy device takes only reset and status
                    nxt_ff.req_ready = cur_ff.rb_s || (REQ_OP == nfc_pkg::OP_RESET)
                        || (REQ_OP == nfc_pkg::OP_STATUS);
                    if (cur_ff.req_ready && !REQ_VALID) begin
                        nxt_ff.req_ready = 1'b0;
                    end
                end
            end
            LOOK: begin
                // Table output is one cycle behind the step
                nxt_ff.st = SETUP;
                nxt_ff.cnt = nfc_pkg::CNT_ZERO;
            end
            RNDLOOK: begin
                // Random out: 05h, two column cycles, E0h; in: 85h, two column cycles
                nxt_ff.cnt = nfc_pkg::CNT_ZERO;
                nxt_ff.st = SETUP;
                if (cur_ff.step == 3'h0) begin
                    nxt_ff.kind = 2'h0;
                    nxt_ff.io = {8'h00, cur_ff.rnd_out ? nfc_pkg::CMD_RND_OUT
                                               : nfc_pkg::CMD_CPB_PROG};
                end else if (cur_ff.step <= {1'b0, nfc_pkg::NUM_ADDR_COL[1:0]}) begin
                    nxt_ff.kind = 2'h1;
                    nxt_ff.io = {8'h00, addr_byte(cur_ff.step - 3'h1, cur_ff.col,
                                                  cur_ff.row, cur_ff.single)};
                end else if (cur_ff.step == 3'h3 && cur_ff.rnd_out) begin
                    nxt_ff.kind = 2'h0;
                    nxt_ff.io = {8'h00, nfc_pkg::CMD_RND_OUT_CONF};
                end else begin
                    nxt_ff.done = 1'b1;
                    nxt_ff.rnd = 1'b0;
                    nxt_ff.st = IDLE;
                end
            end
            SETUP: begin
                if (cur_ff.cnt == nfc_pkg::CNT_ZERO && !cur_ff.rnd) begin
                    nxt_ff.kind = rom_kind;
                    if (rom_kind == 2'h0) begin
                        nxt_ff.io = {8'h00, rom_code};
                    end else if (rom_kind == 2'h1) begin
                        // Erase sends row bytes only
                        nxt_ff.io = {8'h00, addr_byte(
                            (cur_ff.op == nfc_pkg::OP_ERASE) ? cur_ff.aidx + 3'h2 : cur_ff.aidx,
                            cur_ff.col, cur_ff.row, cur_ff.single)};
                    end
                    if (rom_last) begin
                        nxt_ff.done = 1'b1;
                        nxt_ff.st = IDLE;
                    end else if (rom_kind == 2'h3) begin
                        nxt_ff.st = DATA;
                    end
                end
                nxt_ff.cs_n = 1'b0;
                nxt_ff.cle = (nxt_ff.kind == 2'h0);
                nxt_ff.ale = (nxt_ff.kind == 2'h1);
                nxt_ff.oe = 1'b1;
                nxt_ff.cnt = cur_ff.cnt + 4'h1;
                if (cur_ff.cnt + 4'h1 >= nfc_pkg::SETUP_CYC - nfc_pkg::WP_CYC
                    && nxt_ff.st == SETUP) begin
                    nxt_ff.we_n = 1'b0;
                    nxt_ff.cnt = nfc_pkg::CNT_ZERO;
                    nxt_ff.st = LOW;
                end
            end
            DATA: begin
                // Words go out one per write cycle until the source drops valid
                nxt_ff.cle = 1'b0;
                nxt_ff.ale = 1'b0;
                nxt_ff.din_ready = !cur_ff.din_ready && cur_ff.we_n;
                if (cur_ff.din_ready && DIN_VALID) begin
                    nxt_ff.io = DIN_DATA;
                    nxt_ff.data_ph = 1'b1;
                    nxt_ff.we_n = 1'b0;
                    nxt_ff.cnt = nfc_pkg::CNT_ZERO;
                    nxt_ff.st = LOW;
                end else if (cur_ff.din_ready && !DIN_VALID) begin
                    // Program confirm after the page words
                    nxt_ff.io = {8'h00, nfc_pkg::CMD_PROG_CONF};
                    nxt_ff.kind = 2'h0;
                    nxt_ff.cle = 1'b1;
                    nxt_ff.step = 3'h7;
                    nxt_ff.cnt = nfc_pkg::CNT_ZERO;
                    // Straight to the strobe: the table still shows the data step here
                    nxt_ff.we_n = 1'b0;
                    nxt_ff.st = LOW;
                end
            end
            LOW: begin
                nxt_ff.cnt = cur_ff.cnt + 4'h1;
                if (cur_ff.cnt + 4'h1 >= nfc_pkg::WP_CYC) begin
                    nxt_ff.we_n = 1'b1;  // Device samples here, io still held
                    nxt_ff.cnt = nfc_pkg::CNT_ZERO;
                    nxt_ff.st = HIGH;
                end
            end
            HIGH: begin
                nxt_ff.cnt = cur_ff.cnt + 4'h1;
                if (cur_ff.cnt + 4'h1 >= nfc_pkg::HIGH_CYC) begin
                    nxt_ff.cnt = nfc_pkg::CNT_ZERO;
                    if (cur_ff.data_ph) begin
                        nxt_ff.data_ph = 1'b0;
                        nxt_ff.st = DATA;
                    end else if (cur_ff.step == 3'h7) begin
                        nxt_ff.done = 1'b1;
                        nxt_ff.st = IDLE;
                    end else begin
                        if (cur_ff.kind == 2'h1) begin
                            nxt_ff.aidx = cur_ff.aidx + 3'h1;  // never surplus
                        end
                        nxt_ff.step = cur_ff.step + 3'h1;
                        nxt_ff.st = cur_ff.rnd ? RNDLOOK : LOOK;
                    end
                end
            end
            default: begin
                nxt_ff.st = IDLE;
            end
        endcase
    end

    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            cur_ff <= '{st: IDLE, cs_n: 1'b1, we_n: 1'b1, io: nfc_pkg::IO_IDLE, default: '0};
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    // Reads are outside this block; read strobe parked high
    assign REQ_READY = cur_ff.req_ready;
    assign DIN_READY = cur_ff.din_ready;
    assign OP_DONE = cur_ff.done;
    assign DEV_READY = cur_ff.rb_s;
    assign CHIP_SELECT_N = cur_ff.cs_n;
    assign COMMAND_LATCH_ENABLE = cur_ff.cle;
    assign ADDRESS_LATCH_ENABLE = cur_ff.ale;
    assign WRITE_STROBE_N = cur_ff.we_n;
    assign OUTPUT_STROBE_N = cur_ff.cs_n | 1'b1;
    assign IO_OUT = cur_ff.io;
    assign IO_OE = cur_ff.oe;
endmodule // nfc_host

// [logic/nfc_pkg.sv]
package nfc_pkg;
    localparam logic [7:0] CMD_READ = 8'h00;
    localparam logic [7:0] CMD_READ_CONF = 8'h30;
    localparam logic [7:0] CMD_CPB_CONF = 8'h35;
    localparam logic [7:0] CMD_READ_ID = 8'h90;
    localparam logic [7:0] CMD_RESET = 8'hff;
    localparam logic [7:0] CMD_PROG = 8'h80;
    localparam logic [7:0] CMD_PROG_CONF = 8'h10;
    localparam logic [7:0] CMD_CPB_PROG = 8'h85;
    localparam logic [7:0] CMD_ERASE = 8'h60;
    localparam logic [7:0] CMD_ERASE_CONF = 8'hd0;
    localparam logic [7:0] CMD_RND_OUT = 8'h05;
    localparam logic [7:0] CMD_RND_OUT_CONF = 8'he0;
    localparam logic [7:0] CMD_STATUS = 8'h70;

    localparam logic [2:0] OP_READ = 3'h0;
    localparam logic [2:0] OP_READ_ID = 3'h1;
    localparam logic [2:0] OP_CPB_READ = 3'h2;
    localparam logic [2:0] OP_RESET = 3'h3;
    localparam logic [2:0] OP_PROG = 3'h4;
    localparam logic [2:0] OP_CPB_PROG = 3'h5;
    localparam logic [2:0] OP_ERASE = 3'h6;
    localparam logic [2:0] OP_STATUS = 3'h7;

    localparam int MCLK_PERIOD_NS = 10;
    localparam int T_WP_NS = 21;
    localparam int T_WH_NS = 10;
    localparam int T_SETUP_NS = 21;
    localparam int T_HOLD_NS = 5;
    localparam int T_WC_NS = 40;
    localparam logic [3:0] WP_CYC = 4'((T_WP_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS);
    localparam logic [3:0] SETUP_CYC =
        4'((T_SETUP_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS);
    localparam int HOLD_RAW = (T_HOLD_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    localparam int WH_RAW = (T_WH_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    localparam int WC_RAW = (T_WC_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    localparam int HI_RAW = (HOLD_RAW > WH_RAW) ? HOLD_RAW : WH_RAW;
    localparam int LOW_TOT = ((T_SETUP_NS > T_WP_NS) ? 4 : 3);
    localparam logic [3:0] HIGH_CYC =
        4'((HI_RAW + LOW_TOT >= WC_RAW) ? HI_RAW : WC_RAW - LOW_TOT);
    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [2:0] NUM_ADDR_FULL = 3'h5;
    localparam logic [2:0] NUM_ADDR_ROW = 3'h3;
    localparam logic [2:0] NUM_ADDR_COL = 3'h2;
    localparam logic [1:0] DIE_BIT = 2'h1;
    localparam int QDEPTH = 8;
    localparam logic [15:0] IO_IDLE = 16'h0000;
endpackage

// [logic/nfc_seq_rom.sv]
`timescale 1ns/10ps
// Per-step cycle program: kind and byte for each step of an operation
module nfc_seq_rom (
    input wire logic MCLK,
    input wire logic [2:0] op,
    input wire logic [2:0] step,
    output logic [1:0] kind,
    output logic [7:0] code,
    output logic last
);
    // kind: 0 command, 1 address, 2 end, 3 program data words
    logic [1:0] k;
    logic [7:0] c;
    always_comb begin
        k = 2'h2;
        c = 8'h00;
        case (op)
            nfc_pkg::OP_READ, nfc_pkg::OP_CPB_READ: begin
                if (step == 3'h0) begin
                    k = 2'h0;
                    c = nfc_pkg::CMD_READ;
                end else if (step <= nfc_pkg::NUM_ADDR_FULL) begin
                    k = 2'h1;
                end else if (step == 3'h6) begin
                    k = 2'h0;
                    c = (op == nfc_pkg::OP_READ) ? nfc_pkg::CMD_READ_CONF
                        : nfc_pkg::CMD_CPB_CONF;
                end
            end
            nfc_pkg::OP_PROG, nfc_pkg::OP_CPB_PROG: begin
                if (step == 3'h0) begin
                    k = 2'h0;
                    c = (op == nfc_pkg::OP_PROG) ? nfc_pkg::CMD_PROG
                        : nfc_pkg::CMD_CPB_PROG;
                end else if (step <= nfc_pkg::NUM_ADDR_FULL) begin
                    k = 2'h1;
                end else if (step == 3'h6) begin
                    k = 2'h3;
                end
            end
            nfc_pkg::OP_ERASE: begin
                if (step == 3'h0) begin
                    k = 2'h0;
                    c = nfc_pkg::CMD_ERASE;
                end else if (step <= nfc_pkg::NUM_ADDR_ROW) begin
                    k = 2'h1;
                end else if (step == 3'h4) begin
                    k = 2'h0;
                    c = nfc_pkg::CMD_ERASE_CONF;
                end
            end
            nfc_pkg::OP_READ_ID: begin
                if (step == 3'h0) begin
                    k = 2'h0;
                    c = nfc_pkg::CMD_READ_ID;
                end
            end
            nfc_pkg::OP_RESET: begin
                if (step == 3'h0) begin
                    k = 2'h0;
                    c = nfc_pkg::CMD_RESET;
                end
            end
            nfc_pkg::OP_STATUS: begin
                if (step == 3'h0) begin
                    k = 2'h0;
                    c = nfc_pkg::CMD_STATUS;
                end
            end
            default: begin
                k = 2'h2;
            end
        endcase
    end
    // Registered table output; the caller waits one cycle after a step change
    always_ff @(posedge MCLK) begin
        kind <= k;
        code <= c;
        last <= (k == 2'h2);
    end
endmodule // nfc_seq_rom
